//--- inc/sfq_defines.vh
`ifndef SFQ_DEFINES_VH
`define SFQ_DEFINES_VH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFQ_OP_QREAD 8'hEB
`define SFQ_OP_PROG 8'h02
`define SFQ_OP_QPROG_A 8'h32
`define SFQ_OP_QPROG_B 8'h38
`define SFQ_OP_SERASE_A 8'hD7
`define SFQ_OP_SERASE_B 8'h20
`define SFQ_OP_WRITE_ENABLE_COMMAND 8'h06
`define SFQ_OP_WRDI 8'h04
`define SFQ_OP_READ_STATUS_COMMAND 8'h05
`define SFQ_OP_QPI_ON 8'h35
`define SFQ_OP_QPI_OFF 8'hF5

// ----------------------------------------------------------------
// field layout and counts
// ----------------------------------------------------------------
`define SFQ_ADDR_BITS 5'd24
`define SFQ_MODE_BITS 5'd8
`define SFQ_MODE_CLKS 4'h2
`define SFQ_CONT_KEY 4'hA
`define SFQ_PAGE_MSB 8
`define SFQ_SECT_MSB 12
`define SFQ_BP_ALL 4'h8
`define SFQ_FIFO_W 16
`define SFQ_FIFO_D 8
`define SFQ_FIFO_AW 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SFQ_RST_QPI 1'b0
`define SFQ_RST_WEL 1'b0
`define SFQ_RST_BUSY 1'b0
`define SFQ_RST_CONT 1'b0

`endif

//--- src/sfq_fifo.v
`timescale 1ns/10ps
module sfq_fifo #(
  parameter W = 16,
  parameter D = 8,
  parameter AW = 3
) (
  input wire CLOCK,
  input wire RST_N,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid_q,
  input wire out_ready,
  output reg [W-1:0] out_data_q,
  output wire idle
);

  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;

  wire push = in_valid && in_ready;
  wire pop = (cnt_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready);

  assign in_ready = (cnt_q < D[AW:0]);
  assign idle = (cnt_q == {(AW+1){1'b0}}) && !out_valid_q;

  always @(posedge CLOCK) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q <= {W{1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
        out_data_q <= mem_q[rp_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // sfq_fifo

//--- src/sfq_seq.v
`timescale 1ns/10ps
`include "sfq_defines.vh"
module sfq_seq (
  input wire CLOCK,
  input wire RST_N,
  input wire SCK,
  input wire CS_N,
  input wire [3:0] IO_IN,
  output reg [3:0] IO_OUT,
  output reg [3:0] IO_OE,
  input wire [3:0] BP_BITS,
  input wire QE_BIT,
  input wire [3:0] DUMMY_CYCLES,
  output reg BUSY,
  output reg WRITE_ENABLE_LATCH,
  output reg QPI_MODE,
  output reg CONT_READ,
  output reg [23:0] ARR_ADDR,
  output reg ARR_RD_REQ,
  input wire [7:0] ARR_RDATA,
  output reg PBUF_CLR,
  output wire PBUF_WE,
  output wire [7:0] PBUF_OFS,
  output wire [7:0] PBUF_DATA,
  input wire PBUF_READY,
  output reg PROG_START,
  output reg ERASE_START,
  input wire OP_DONE
);

  // ----------------------------------------------------------------
  // states and command kinds
  // ----------------------------------------------------------------
  localparam S_IDLE = 4'd0;
  localparam S_CMD = 4'd1;
  localparam S_ADDR = 4'd2;
  localparam S_MODE = 4'd3;
  localparam S_DUMMY = 4'd4;
  localparam S_RDATA = 4'd5;
  localparam S_STAT = 4'd6;
  localparam S_WDATA = 4'd7;
  localparam S_DONE = 4'd8;
  localparam S_IGN = 4'd9;

  localparam K_NONE = 3'd0;
  localparam K_READ = 3'd1;
  localparam K_PROG = 3'd2;
  localparam K_ERASE = 3'd3;
  localparam K_WEN = 3'd4;
  localparam K_WDIS = 3'd5;
  localparam K_QON = 3'd6;
  localparam K_QOFF = 3'd7;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [5:0] s1_q;
  reg [5:0] s2_q;
  reg sck_d_q;
  reg cs_d_q;

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      s1_q <= 6'h30;
      s2_q <= 6'h30;
      sck_d_q <= 1'b1;
      cs_d_q <= 1'b1;
    end else begin
      s1_q <= {SCK, CS_N, IO_IN};
      s2_q <= s1_q;
      sck_d_q <= s2_q[5];
      cs_d_q <= s2_q[4];
    end
  end

  wire sck_s = s2_q[5];
  wire cs_s = s2_q[4];
  wire [3:0] io_s = s2_q[3:0];
  wire rise = sck_s && !sck_d_q && !cs_s;
  wire fall = !sck_s && sck_d_q && !cs_s;
  wire cs_fall = !cs_s && cs_d_q;
  wire cs_rise = cs_s && !cs_d_q;

  // ----------------------------------------------------------------
  // working registers
  // ----------------------------------------------------------------
  reg [3:0] st_q;
  reg [2:0] kind_q;
  reg lw_q;
  reg [4:0] cnt_q;
  reg [23:0] sh_q;
  reg [7:0] osh_q;
  reg [2:0] oc_q;
  reg [7:0] rbuf_q;
  reg rd_pend_q;
  reg got_q;
  reg pend_q;
  reg push_q;
  reg [15:0] push_data_q;

  wire [2:0] step = lw_q ? 3'd4 : 3'd1;
  wire [4:0] cnt_n = cnt_q + {2'b00, step};
  wire byte_end = (cnt_n[2:0] == 3'd0);
  wire [23:0] sh_n = lw_q ? {sh_q[19:0], io_s} : {sh_q[22:0], io_s[0]};
  wire [7:0] stat = {1'b0, QE_BIT, BP_BITS, WRITE_ENABLE_LATCH, BUSY};
  wire [7:0] obyte = (oc_q != 3'd0) ? osh_q : ((st_q == S_STAT) ? stat : rbuf_q);
  // fewer than the two mode clocks would clash with the mode byte
  wire [3:0] dmy = (DUMMY_CYCLES < `SFQ_MODE_CLKS) ? `SFQ_MODE_CLKS : DUMMY_CYCLES;

  wire [8:0] blk = {1'b0, ~ARR_ADDR[23:16]};
  wire [8:0] lim = 9'h001 << (BP_BITS - 4'h1);
  wire prot = (BP_BITS != 4'h0) && ((BP_BITS > `SFQ_BP_ALL) || (blk < lim));

  wire prog_ok = (kind_q == K_PROG) && (st_q == S_WDATA) && got_q && (cnt_q == 5'd0)
                 && WRITE_ENABLE_LATCH && !prot && !BUSY;
  // only that sector goes to ones
  wire erase_ok = (kind_q == K_ERASE) && (st_q == S_DONE) && WRITE_ENABLE_LATCH && !prot && !BUSY;

  wire fifo_ready;
  wire fifo_idle;

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      st_q <= S_IDLE;
      kind_q <= K_NONE;
      lw_q <= 1'b0;
      cnt_q <= 5'd0;
      sh_q <= 24'h00_0000;
      osh_q <= 8'h00;
      oc_q <= 3'd0;
      rbuf_q <= 8'h00;
      rd_pend_q <= 1'b0;
      got_q <= 1'b0;
      pend_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 16'h0000;
      IO_OUT <= 4'h0;
      IO_OE <= 4'h0;
      BUSY <= `SFQ_RST_BUSY;
      WRITE_ENABLE_LATCH <= `SFQ_RST_WEL;
      QPI_MODE <= `SFQ_RST_QPI;
      CONT_READ <= `SFQ_RST_CONT;
      ARR_ADDR <= 24'h00_0000;
      ARR_RD_REQ <= 1'b0;
      PBUF_CLR <= 1'b0;
      PROG_START <= 1'b0;
      ERASE_START <= 1'b0;
    end else begin
      ARR_RD_REQ <= 1'b0;
      PBUF_CLR <= 1'b0;
      PROG_START <= 1'b0;
      ERASE_START <= 1'b0;
      push_q <= 1'b0;
      rd_pend_q <= ARR_RD_REQ;
      // array answers in the cycle after the request is seen
      if (rd_pend_q) begin
        rbuf_q <= ARR_RDATA;
      end

      // ----------------------------------------------------------------
      // frame start
      // ----------------------------------------------------------------
      if (cs_fall) begin
        cnt_q <= 5'd0;
        oc_q <= 3'd0;
        got_q <= 1'b0;
        if (CONT_READ && !BUSY) begin
          st_q <= S_ADDR;
          kind_q <= K_READ;
          lw_q <= 1'b1;
        end else begin
          st_q <= S_CMD;
          kind_q <= K_NONE;
          lw_q <= QPI_MODE;
        end
      end else if (cs_rise) begin
        // ----------------------------------------------------------------
        // frame end
        // ----------------------------------------------------------------
        st_q <= S_IDLE;
        IO_OE <= 4'h0;
        if (prog_ok) begin
          BUSY <= 1'b1;
          pend_q <= 1'b1;
        end
        if (erase_ok) begin
          BUSY <= 1'b1;
          ERASE_START <= 1'b1;
        end
        if (st_q == S_DONE && !BUSY) begin
          case (kind_q)
            K_WEN: WRITE_ENABLE_LATCH <= 1'b1;
            K_WDIS: WRITE_ENABLE_LATCH <= 1'b0;
            K_QON: QPI_MODE <= 1'b1;
            K_QOFF: QPI_MODE <= 1'b0;
            default: ;
          endcase
        end
      end else if (rise) begin
        sh_q <= sh_n;
        cnt_q <= cnt_n;
        case (st_q)
          S_CMD: begin
            if (byte_end) begin
              cnt_q <= 5'd0;
              // while busy, any opcode but read status falls to ignore
              if (BUSY && sh_n[7:0] != `SFQ_OP_READ_STATUS_COMMAND) begin
                st_q <= S_IGN;
              end else begin
                case (sh_n[7:0])
                  `SFQ_OP_READ_STATUS_COMMAND: st_q <= S_STAT;
                  // same opcode, nibble or bit wide
                  `SFQ_OP_QREAD: begin
                    st_q <= S_ADDR;
                    kind_q <= K_READ;
                    lw_q <= 1'b1;
                  end
                  `SFQ_OP_PROG: begin
                    st_q <= S_ADDR;
                    kind_q <= K_PROG;
                  end
                  `SFQ_OP_QPROG_A, `SFQ_OP_QPROG_B: begin
                    st_q <= QE_BIT ? S_ADDR : S_IGN;
                    kind_q <= K_PROG;
                    lw_q <= 1'b1;
                  end
                  `SFQ_OP_SERASE_A, `SFQ_OP_SERASE_B: begin
                    st_q <= S_ADDR;
                    kind_q <= K_ERASE;
                  end
                  `SFQ_OP_WRITE_ENABLE_COMMAND: begin
                    st_q <= S_DONE;
                    kind_q <= K_WEN;
                  end
                  `SFQ_OP_WRDI: begin
                    st_q <= S_DONE;
                    kind_q <= K_WDIS;
                  end
                  `SFQ_OP_QPI_ON: begin
                    st_q <= QPI_MODE ? S_IGN : S_DONE;
                    kind_q <= K_QON;
                  end
                  `SFQ_OP_QPI_OFF: begin
                    st_q <= QPI_MODE ? S_DONE : S_IGN;
                    kind_q <= K_QOFF;
                  end
                  default: st_q <= S_IGN;
                endcase
              end
            end
          end
          S_ADDR: begin
            if (cnt_n == `SFQ_ADDR_BITS) begin
              cnt_q <= 5'd0;
              ARR_ADDR <= sh_n;
              case (kind_q)
                K_READ: begin
                  st_q <= S_MODE;
                  ARR_RD_REQ <= 1'b1;
                end
                K_PROG: begin
                  // fresh page image, unsent bytes keep array value
                  st_q <= S_WDATA;
                  PBUF_CLR <= 1'b1;
                end
                default: st_q <= S_DONE;
              endcase
            end
          end
          S_MODE: begin
            if (cnt_n == `SFQ_MODE_BITS) begin
              cnt_q <= 5'd0;
              CONT_READ <= (sh_n[7:4] == `SFQ_CONT_KEY);
              st_q <= (dmy == `SFQ_MODE_CLKS) ? S_RDATA : S_DUMMY;
            end
          end
          S_DUMMY: begin
            cnt_q <= cnt_q + 5'd1;
            if (cnt_q + 5'd1 == {1'b0, dmy - `SFQ_MODE_CLKS}) begin
              st_q <= S_RDATA;
            end
          end
          S_WDATA: begin
            if (byte_end) begin
              cnt_q <= 5'd0;
              got_q <= 1'b1;
              push_q <= 1'b1;
              push_data_q <= {ARR_ADDR[7:0], sh_n[7:0]};
              ARR_ADDR[7:0] <= ARR_ADDR[7:0] + 8'h01;
            end
          end
          default: ;
        endcase
      end else if (fall && (st_q == S_STAT || st_q == S_RDATA)) begin
        // msb on the highest active line
        IO_OUT <= lw_q ? obyte[7:4] : {2'b00, obyte[7], 1'b0};
        // lines driven only in output phases
        IO_OE <= lw_q ? 4'hF : 4'h2;
        osh_q <= lw_q ? {obyte[3:0], 4'h0} : {obyte[6:0], 1'b0};
        oc_q <= oc_q + step;
        if (oc_q == 3'd0 && st_q == S_RDATA) begin
          // next byte, wraps at top of memory
          ARR_ADDR <= ARR_ADDR + 24'h00_0001;
          ARR_RD_REQ <= 1'b1;
        end
      end

      // hold the launch until every page byte has left the fifo
      if (pend_q && fifo_idle && !push_q) begin
        pend_q <= 1'b0;
        PROG_START <= 1'b1;
      end
      if (BUSY && !pend_q && OP_DONE) begin
        BUSY <= 1'b0;
        WRITE_ENABLE_LATCH <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // page byte fifo
  // ----------------------------------------------------------------
  // a byte takes at least two link clocks, so a full fifo means a
  // stalled page buffer; such a byte is lost rather than overwriting
  wire [15:0] fifo_out;

  sfq_fifo #(
    .W(`SFQ_FIFO_W),
    .D(`SFQ_FIFO_D),
    .AW(`SFQ_FIFO_AW)
  ) u_fifo (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .in_valid(push_q),
    .in_ready(fifo_ready),
    .in_data(push_data_q),
    .out_valid_q(PBUF_WE),
    .out_ready(PBUF_READY),
    .out_data_q(fifo_out),
    .idle(fifo_idle)
  );

  assign PBUF_OFS = fifo_out[15:8];
  assign PBUF_DATA = fifo_out[7:0];

endmodule // sfq_seq

//--- verification/sfq_chk.sv
`timescale 1ns/10ps
module sfq_chk (
  input wire CLOCK,
  input wire RST_N,
  input wire CS_N,
  input wire [3:0] IO_OE,
  input wire BUSY,
  input wire WRITE_ENABLE_LATCH,
  input wire QPI_MODE,
  input wire [23:0] ARR_ADDR,
  input wire ARR_RD_REQ,
  input wire PROG_START,
  input wire ERASE_START,
  input wire OP_DONE
);
  // ------
  // helper state
  // ------
  // done only counts once a start was issued, as the array side may answer early
  reg run_q;
  reg rd_q;
  reg [23:0] last_q;
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      run_q <= 1'b0;
    end else if (PROG_START || ERASE_START) begin
      run_q <= 1'b1;
    end else if (!BUSY) begin
      run_q <= 1'b0;
    end
    if (!RST_N || CS_N) begin
      rd_q <= 1'b0;
    end else if (ARR_RD_REQ) begin
      rd_q <= 1'b1;
    end
    if (ARR_RD_REQ) begin
      last_q <= ARR_ADDR;
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  sequence s_launch;
    $rose(BUSY);
  endsequence
  sequence s_finish;
    run_q && OP_DONE;
  endsequence
  // ------
  // assertions
  // ------
  a_busy_needs_wel: assert property (
    s_launch |-> $past(WRITE_ENABLE_LATCH) && WRITE_ENABLE_LATCH) else $error("busy rose without latch");
  a_launch_cs_high: assert property (
    s_launch |-> CS_N && $past(CS_N)) else $error("launch inside a frame");
  a_erase_at_rise: assert property (
    ERASE_START |-> $rose(BUSY)) else $error("erase start not with busy rise");
  a_prog_while_busy: assert property (
    PROG_START |-> BUSY && WRITE_ENABLE_LATCH) else $error("program start outside busy");
  a_done_clears: assert property (
    s_finish |=> !BUSY && !WRITE_ENABLE_LATCH) else $error("busy or latch left after done");
  a_busy_holds: assert property (
    BUSY && !OP_DONE |=> BUSY) else $error("busy dropped early");
  a_no_read_busy: assert property (
    BUSY |-> !ARR_RD_REQ) else $error("array read while busy");
  a_read_addr_step: assert property (
    ARR_RD_REQ && rd_q |-> ARR_ADDR == last_q + 24'h00_0001) else $error("read address step");
  a_lines_off_idle: assert property (
    CS_N [*6] |-> IO_OE == 4'h0) else $error("lines driven while deselected");
  a_mode_at_cs: assert property (
    $changed(QPI_MODE) |-> CS_N) else $error("mode changed inside a frame");
  a_wel_at_cs: assert property (
    $rose(WRITE_ENABLE_LATCH) |-> CS_N) else $error("latch set inside a frame");
endmodule // sfq_chk

bind sfq_seq sfq_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .CS_N(CS_N), .IO_OE(IO_OE),
  .BUSY(BUSY), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .QPI_MODE(QPI_MODE), .ARR_ADDR(ARR_ADDR),
  .ARR_RD_REQ(ARR_RD_REQ), .PROG_START(PROG_START), .ERASE_START(ERASE_START),
  .OP_DONE(OP_DONE));

//--- verification/sfq_host.sv
`timescale 1ns/10ps
module sfq_host (
  input wire clk,
  input wire [3:0] io_in,
  output reg sck,
  output reg cs_n,
  output reg [3:0] io_o,
  output reg [3:0] io_oe
);
  // ------
  // link host
  // ------
  // clock idles high between frames; data moves at the fall, stable over the rise
  initial begin
    sck = 1'b1;
    cs_n = 1'b1;
    io_o = 4'h0;
    io_oe = 4'h0;
  end
  task tick(input [3:0] v, input [3:0] oe);
    begin
      io_o <= v;
      io_oe <= oe;
      sck <= 1'b0;
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
  task start;
    begin
      cs_n <= 1'b0;
      @(posedge clk);
    end
  endtask
  task stop;
    begin
      io_oe <= 4'h0;
      cs_n <= 1'b1;
      repeat (12) @(posedge clk);
    end
  endtask
  task put(input [7:0] b, input q);
    integer i;
    begin
      if (q) begin
        tick(b[7:4], 4'hF);
        tick(b[3:0], 4'hF);
      end else begin
        for (i = 7; i >= 0; i = i - 1) tick({3'h0, b[i]}, 4'h1);
      end
    end
  endtask
  task idle(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) tick(4'h0, 4'h0);
    end
  endtask
  task get(output [7:0] b);
    begin
      tick(4'h0, 4'h0);
      b[7:4] = io_in;
      tick(4'h0, 4'h0);
      b[3:0] = io_in;
    end
  endtask
endmodule // sfq_host

//--- verification/sfq_seq_tb.sv
`timescale 1ns/10ps
`include "sfq_defines.vh"
module sfq_seq_tb;
  reg clock, rst_n, op_done, pbuf_ready, qe;
  reg [3:0] bp, dummy;
  reg [7:0] rdata, b0, b1;
  reg [9:0] dly;
  reg [23:0] st_addr;
  reg [15:0] pq[$];
  integer error_cnt, checked, n_start, n_rd, k;
  wire sck, cs_n, busy, write_enable_latch, four_line_command_mode, cont, rd_req, pclr, pwe, pstart, estart;
  wire [3:0] h_o, h_oe, io_out, io_oe, io_w;
  wire [23:0] addr;
  wire [7:0] pofs, pdat;
  // undriven lines float high through the pull-up
  assign io_w = (io_oe & io_out) | (~io_oe & ((h_oe & h_o) | ~h_oe));
  sfq_seq DUT (.CLOCK(clock), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .IO_IN(io_w),
    .IO_OUT(io_out), .IO_OE(io_oe), .BP_BITS(bp), .QE_BIT(qe), .DUMMY_CYCLES(dummy),
    .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .QPI_MODE(four_line_command_mode), .CONT_READ(cont), .ARR_ADDR(addr),
    .ARR_RD_REQ(rd_req), .ARR_RDATA(rdata), .PBUF_CLR(pclr), .PBUF_WE(pwe),
    .PBUF_OFS(pofs), .PBUF_DATA(pdat), .PBUF_READY(pbuf_ready), .PROG_START(pstart),
    .ERASE_START(estart), .OP_DONE(op_done));
  sfq_host host (.clk(clock), .io_in(io_w), .sck(sck), .cs_n(cs_n), .io_o(h_o),
    .io_oe(h_oe));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ------
  // array side
  // ------
  // page buffer stalls every other cycle so the fifo output has to wait for ready
  always @(posedge clock) begin
    pbuf_ready <= ~pbuf_ready;
    if (rd_req) begin
      rdata <= addr[7:0] ^ 8'h5A;
      n_rd <= n_rd + 1;
    end
    if (pclr) pq.delete();
    if (pwe && pbuf_ready) pq.push_back({pofs, pdat});
    op_done <= (dly == 10'h001);
    if (pstart || estart) begin
      n_start <= n_start + 1;
      st_addr <= addr;
      dly <= 10'h3E8;
    end else if (dly != 10'h000) begin
      dly <= dly - 10'h001;
    end
  end
  // ------
  // helpers
  // ------
  task chk(input [47:0] seen, input [47:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (error_cnt == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task wait_busy(input v);
    integer i;
    begin
      for (i = 0; i < 1500 && busy !== v; i = i + 1) @(posedge clock);
      if (busy !== v) begin
        error_cnt = error_cnt + 1;
        test_done;
      end
    end
  endtask
  task cmd(input [7:0] op, input q);
    begin
      host.start;
      host.put(op, q);
      host.stop;
    end
  endtask
  task adr(input [23:0] a, input q);
    begin
      host.put(a[23:16], q);
      host.put(a[15:8], q);
      host.put(a[7:0], q);
    end
  endtask
  task head(input [7:0] op, input [23:0] a, input q);
    begin
      host.start;
      host.put(op, q);
      adr(a, q);
    end
  endtask
  // ------
  // scenarios
  // ------
  task t_prog;
    begin
      cmd(`SFQ_OP_WRITE_ENABLE_COMMAND, 0);
      chk(write_enable_latch, 1);
      pq.delete();
      head(`SFQ_OP_PROG, 24'h12_34FE, 0);
      host.put(8'hA1, 0);
      host.put(8'hB2, 0);
      host.put(8'hC3, 0);
      host.stop;
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk(st_addr[23:8], 16'h1234);
      chk({pq[0], pq[1], pq[2]}, 48'hFEA1_FFB2_00C3);
      chk(write_enable_latch, 0);
    end
  endtask
  task t_refuse;
    begin
      head(`SFQ_OP_PROG, 24'h00_0100, 0);
      host.put(8'h00, 0);
      host.stop;
      chk(busy, 0);
      cmd(`SFQ_OP_WRITE_ENABLE_COMMAND, 0);
      bp <= 4'h1;
      head(`SFQ_OP_PROG, 24'hFF_0000, 0);
      host.put(8'h00, 0);
      host.stop;
      chk(busy, 0);
      bp <= 4'h0;
      cmd(`SFQ_OP_WRITE_ENABLE_COMMAND, 0);
      head(`SFQ_OP_PROG, 24'h00_0100, 0);
      host.put(8'h00, 0);
      host.tick(4'h0, 4'h1);
      host.stop;
      chk(busy, 0);
      chk(n_start, 1);
    end
  endtask
  task t_erase;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        cmd(`SFQ_OP_WRITE_ENABLE_COMMAND, 0);
        head(k ? `SFQ_OP_SERASE_A : `SFQ_OP_SERASE_B, 24'h03_5678, 0);
        host.stop;
        wait_busy(1'b1);
        cmd(`SFQ_OP_WRDI, 0);
        head(`SFQ_OP_QREAD, 24'h00_0000, 0);
        host.idle(6);
        host.stop;
        chk({write_enable_latch, busy}, 2'b11);
        chk(n_rd, 0);
        wait_busy(1'b0);
        chk(st_addr[23:12], 12'h035);
        chk(write_enable_latch, 0);
      end
    end
  endtask
  task t_qread;
    begin
      cmd(`SFQ_OP_QPI_ON, 0);
      chk(four_line_command_mode, 1);
      head(`SFQ_OP_QREAD, 24'hFF_FFFF, 1);
      host.put(8'hA5, 1);
      host.idle(4);
      host.get(b0);
      host.get(b1);
      host.stop;
      chk({b0, b1}, 16'hA55A);
      chk(cont, 1);
      host.start;
      adr(24'h00_1010, 1);
      host.put(8'h50, 1);
      host.idle(4);
      host.get(b0);
      host.stop;
      chk(b0, 8'h4A);
      chk({cont, four_line_command_mode}, 2'b01);
    end
  endtask
  task t_qprog;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        qe <= k[0];
        cmd(`SFQ_OP_WRITE_ENABLE_COMMAND, 1);
        head(k ? `SFQ_OP_QPROG_A : `SFQ_OP_QPROG_B, 24'h00_20FF, 1);
        host.put(8'h5C, 1);
        host.put(8'h3D, 1);
        host.stop;
        chk(busy, k[0]);
      end
      host.start;
      host.put(`SFQ_OP_READ_STATUS_COMMAND, 1);
      host.get(b0);
      host.stop;
      chk(b0, 8'h43);
      wait_busy(1'b0);
      chk({pq[0], pq[1]}, 32'hFF5C_003D);
      chk(st_addr[23:8], 16'h0020);
      cmd(`SFQ_OP_QPI_OFF, 1);
      chk(four_line_command_mode, 0);
    end
  endtask
  initial begin
    error_cnt = 0;
    checked = 0;
    n_start = 0;
    n_rd = 0;
    rst_n = 1'b0;
    op_done = 1'b0;
    pbuf_ready = 1'b0;
    qe = 1'b0;
    bp = 4'h0;
    dummy = 4'h6;
    rdata = 8'h00;
    dly = 10'h000;
    st_addr = 24'h00_0000;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_prog;
    t_refuse;
    t_erase;
    t_qread;
    t_qprog;
    test_done;
  end
endmodule // sfq_seq_tb
